// file: verilog/eeprom_page_host.sv
// host controller that reads, page writes and locks a paged parallel eeprom
// How it works
// RQ1: device floats and ignores pins when deselected
// RQ2: output enable stays high during write strobes
// RQ3: same page address on every page strobe
// RQ4: next page byte within load window
// RQ5: lock enable sequence takes effect after program
// RQ6: lock disable sequence takes effect after program
// RQ7: command bytes hex, command addresses bits 14-0
// RQ8: unlock sequence then one to 128 bytes
// RQ9: window overrun ends load, programming starts
// RQ10: bit 7 complemented until programming ends
// RQ11: bit 6 toggles per read while programming
// RQ12: unprefixed locked write still runs write timer
// RQ13: programming ends within 10 ms, then accepts
`timescale 1ns/1ns
module eeprom_page_host
   import eeprom_host_pkg::*;
#(
   parameter int LOAD_IDLE_CYC = LOAD_WINDOW_CYC / 2,
   parameter int POLL_LIMIT_CYC = PROGRAM_CYCLE_CYC,
   // command bytes and addresses: arbitrary values, set them for the part used
   parameter logic [SEQ_LEN-1:0][CMD_ADDR_W-1:0] LOCK_ADDR = {15'h0003, 15'h0002, 15'h0001},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] LOCK_ON_DATA = {8'h03, 8'h02, 8'h01},
   parameter logic [SEQ_LEN-1:0][DATA_W-1:0] LOCK_OFF_DATA = {8'h06, 8'h05, 8'h04}
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // user command port
   input wire logic cmd_valid_i,
   output logic cmd_ready_o,
   input wire op_e cmd_op_i,
   input wire logic [ADDR_W-1:0] cmd_addr_i,
   input wire logic [DATA_W-1:0] cmd_data_i,
   input wire logic wr_locked_i,
   // user answers
   output logic rd_valid_o,
   output logic [DATA_W-1:0] rd_data_o,
   output logic busy_o,
   output logic timeout_o,
   // eeprom pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [DATA_W-1:0] dq_i
);

   localparam int TMR_W = $clog2(POLL_LIMIT_CYC + LOAD_IDLE_CYC + 1);
   localparam logic [TMR_W-1:0] LOAD_LAST = TMR_W'(LOAD_IDLE_CYC - 1);
   localparam logic [TMR_W-1:0] POLL_LAST = TMR_W'(POLL_LIMIT_CYC - 1);
   localparam logic [1:0] SEQ_LAST = 2'(SEQ_LEN - 1);
   localparam logic [BYTE_CNT_W-1:0] PAGE_FULL = BYTE_CNT_W'(PAGE_BYTES);

   typedef enum logic [2:0] {S_IDLE, S_SEQ, S_DATA, S_LOAD, S_READ, S_POLL1, S_POLL2} state_e;
   typedef logic [ADDR_W-PAGE_LSB-1:0] page_t;

   function automatic page_t page_of(input logic [ADDR_W-1:0] a);
      page_of = a[ADDR_W-1:PAGE_LSB];
   endfunction : page_of

   strobe_if cyc ();

   state_e st_q, st_d;
   op_e op_q, op_d;
   logic [ADDR_W-1:0] addr_q, addr_d, poll_addr_q, poll_addr_d;
   logic [DATA_W-1:0] data_q, data_d, last_q, last_d, prev_q, prev_d;
   logic [DATA_W-1:0] rd_data_q, rd_data_d;
   logic [1:0] seq_q, seq_d;
   logic [BYTE_CNT_W-1:0] cnt_q, cnt_d;
   logic [TMR_W-1:0] tmr_q, tmr_d;
   page_t page_q, page_d;
   logic sent_q, sent_d, has_data_q, has_data_d, rd_valid_q, rd_valid_d, tout_q, tout_d;
   logic load_take, settled;

   // a page may only grow with writes to the same page, up to its size
   assign load_take = (st_q == S_LOAD) && (cmd_op_i == OP_WRITE)
                      && (page_of(cmd_addr_i) == page_q) && (cnt_q != PAGE_FULL); // RQ3 RQ8
   assign cmd_ready_o = (st_q == S_IDLE) || load_take;

   // done when bit 6 stops toggling and, after data, bit 7 matches the last byte written
   assign settled = (prev_q[TOGGLE_BIT] == cyc.rdata[TOGGLE_BIT]) // RQ11
                    && (!has_data_q || cyc.rdata[POLL_BIT] == last_q[POLL_BIT]); // RQ10

   always_comb begin
      cyc.req = 1'b0;
      if (st_q == S_SEQ || st_q == S_DATA || st_q == S_READ || st_q == S_POLL1
          || st_q == S_POLL2) begin
         cyc.req = !sent_q;
      end
      cyc.wr = (st_q == S_SEQ) || (st_q == S_DATA);
      cyc.addr = addr_q;
      cyc.wdata = data_q;
      if (st_q == S_SEQ) begin
         cyc.addr = ADDR_W'(LOCK_ADDR[seq_q]); // RQ7
         cyc.wdata = (op_q == OP_LOCK_OFF) ? LOCK_OFF_DATA[seq_q] : LOCK_ON_DATA[seq_q];
      end else if (st_q == S_POLL1 || st_q == S_POLL2) begin
         cyc.addr = poll_addr_q;
      end
   end

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      addr_d = addr_q;
      data_d = data_q;
      poll_addr_d = poll_addr_q;
      last_d = last_q;
      prev_d = prev_q;
      rd_data_d = rd_data_q;
      seq_d = seq_q;
      cnt_d = cnt_q;
      page_d = page_q;
      has_data_d = has_data_q;
      rd_valid_d = 1'b0;
      tout_d = 1'b0;
      tmr_d = (tmr_q == POLL_LAST) ? tmr_q : tmr_q + 1'b1;
      sent_d = sent_q;
      if (cyc.req) begin
         sent_d = 1'b1;
      end
      if (cyc.done) begin
         sent_d = 1'b0;
      end
      case (st_q)
         S_IDLE: begin
            if (cmd_valid_i) begin
               op_d = cmd_op_i;
               addr_d = cmd_addr_i;
               data_d = cmd_data_i;
               seq_d = '0;
               cnt_d = '0;
               case (cmd_op_i)
                  OP_READ: st_d = S_READ;
                  // a locked part needs the sequence ahead of each page
                  OP_WRITE: st_d = wr_locked_i ? S_SEQ : S_DATA; // RQ8 RQ12
                  default: begin
                     has_data_d = 1'b0;
                     poll_addr_d = cmd_addr_i;
                     st_d = S_SEQ;
                  end
               endcase
            end
         end
         S_SEQ: begin
            if (cyc.done) begin
               if (seq_q == SEQ_LAST) begin
                  seq_d = '0;
                  tmr_d = '0;
                  // lock change with no data still programs: poll it out
                  st_d = (op_q == OP_WRITE) ? S_DATA : S_POLL1; // RQ5 RQ6
               end else begin
                  seq_d = seq_q + 1'b1;
               end
            end
         end
         S_DATA: begin
            if (cyc.done) begin
               tmr_d = '0;
               cnt_d = cnt_q + 1'b1;
               page_d = page_of(addr_q);
               poll_addr_d = addr_q;
               last_d = data_q;
               has_data_d = 1'b1;
               st_d = S_LOAD;
            end
         end
         S_LOAD: begin
            if (cmd_valid_i && load_take) begin
               addr_d = cmd_addr_i;
               data_d = cmd_data_i;
               st_d = S_DATA;
            end else if (cmd_valid_i || tmr_q == LOAD_LAST) begin // RQ4 RQ9
               tmr_d = '0;
               st_d = S_POLL1;
            end
         end
         S_READ: begin
            if (cyc.done) begin
               rd_data_d = cyc.rdata;
               rd_valid_d = 1'b1;
               st_d = S_IDLE;
            end
         end
         S_POLL1: begin
            if (cyc.done) begin
               prev_d = cyc.rdata;
               st_d = S_POLL2;
            end
         end
         S_POLL2: begin
            if (cyc.done) begin
               prev_d = cyc.rdata;
               if (settled) begin
                  st_d = S_IDLE; // RQ13
               end else if (tmr_q == POLL_LAST) begin
                  tout_d = 1'b1; // RQ13
                  st_d = S_IDLE;
               end
            end
         end
         default: st_d = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= S_IDLE;
         op_q <= OP_READ;
         addr_q <= '0;
         data_q <= '0;
         poll_addr_q <= '0;
         last_q <= '0;
         prev_q <= '0;
         rd_data_q <= '0;
         seq_q <= '0;
         cnt_q <= '0;
         tmr_q <= '0;
         page_q <= '0;
         sent_q <= 1'b0;
         has_data_q <= 1'b0;
         rd_valid_q <= 1'b0;
         tout_q <= 1'b0;
      end else begin
         st_q <= st_d;
         op_q <= op_d;
         addr_q <= addr_d;
         data_q <= data_d;
         poll_addr_q <= poll_addr_d;
         last_q <= last_d;
         prev_q <= prev_d;
         rd_data_q <= rd_data_d;
         seq_q <= seq_d;
         cnt_q <= cnt_d;
         tmr_q <= tmr_d;
         page_q <= page_d;
         sent_q <= sent_d;
         has_data_q <= has_data_d;
         rd_valid_q <= rd_valid_d;
         tout_q <= tout_d;
      end
   end

   pin_cycle_engine u_engine (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .cyc(cyc),
      .ce_n_o(ce_n_o),
      .oe_n_o(oe_n_o),
      .we_n_o(we_n_o),
      .addr_o(addr_o),
      .dq_o(dq_o),
      .dq_oe_o(dq_oe_o),
      .dq_i(dq_i)
   );

   assign rd_valid_o = rd_valid_q;
   assign rd_data_o = rd_data_q;
   assign timeout_o = tout_q;
   assign busy_o = (st_q != S_IDLE);

endmodule : eeprom_page_host

// file: verilog/eeprom_host_pkg.sv
// constants and types shared by the paged eeprom host controller
package eeprom_host_pkg;

   // clock and documented pin timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US = 1000;
   localparam int NS_PER_MS = 1000000;
   localparam int T_WP_NS = 100;
   localparam int T_WPH_NS = 50;
   localparam int T_ACC_NS = 120;
   localparam int T_OEHP_NS = 150;
   localparam int BYTE_LOAD_WINDOW_US = 150;
   localparam int PROGRAM_CYCLE_TIME_MS = 10;

   // least times round up, longest times round down
   localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int OEHP_CYC = (T_OEHP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LOAD_WINDOW_CYC = BYTE_LOAD_WINDOW_US * NS_PER_US / CLK_PERIOD_NS;
   localparam int PROGRAM_CYCLE_CYC = PROGRAM_CYCLE_TIME_MS * NS_PER_MS / CLK_PERIOD_NS;
   localparam int SYNC_STAGES = 2;
   localparam int CYC_CNT_W = 8;

   // array shape
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int PAGE_LSB = 7;
   localparam int PAGE_BYTES = 128;
   localparam int BYTE_CNT_W = 8;
   localparam int CMD_ADDR_W = 15;
   localparam int SEQ_LEN = 3;
   localparam int TOGGLE_BIT = 6;
   localparam int POLL_BIT = 7;

   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_LOCK_ON,
      OP_LOCK_OFF
   } op_e;

endpackage : eeprom_host_pkg

// file: verilog/strobe_if.sv
// single pin cycle request and answer between sequencer and pin engine
`timescale 1ns/1ns
interface strobe_if import eeprom_host_pkg::*; ();
   logic req;
   logic wr;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic done;
   logic [DATA_W-1:0] rdata;

   modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
   modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface : strobe_if

// file: verilog/pin_cycle_engine.sv
// drives one timed read or write cycle on the eeprom pins
`timescale 1ns/1ns
module pin_cycle_engine
   import eeprom_host_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // request from the sequencer
   strobe_if.eng cyc,
   // eeprom pins
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   input wire logic [DATA_W-1:0] dq_i
);

   localparam logic [CYC_CNT_W-1:0] WP_LAST = CYC_CNT_W'(WP_CYC - 1);
   localparam logic [CYC_CNT_W-1:0] WPH_LAST = CYC_CNT_W'(WPH_CYC - 1);
   localparam logic [CYC_CNT_W-1:0] RD_LAST = CYC_CNT_W'(ACC_CYC + SYNC_STAGES - 1);
   localparam logic [CYC_CNT_W-1:0] REC_LAST = CYC_CNT_W'(OEHP_CYC - 1);

   typedef enum logic [2:0] {C_IDLE, C_WR_LOW, C_WR_HIGH, C_RD_ACC, C_RD_REC} cyc_state_e;

   cyc_state_e st_q, st_d;
   logic [CYC_CNT_W-1:0] cnt_q, cnt_d;
   logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d, dq_oe_q, dq_oe_d;
   logic done_q, done_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] dq_q, dq_d, rdata_q, rdata_d;
   logic [DATA_W-1:0] dq_m_q, dq_s_q;

   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q + 1'b1;
      ce_n_d = ce_n_q;
      oe_n_d = oe_n_q;
      we_n_d = we_n_q;
      dq_oe_d = dq_oe_q;
      addr_d = addr_q;
      dq_d = dq_q;
      rdata_d = rdata_q;
      done_d = 1'b0;
      case (st_q)
         C_IDLE: begin
            cnt_d = '0;
            ce_n_d = 1'b1; // RQ1
            oe_n_d = 1'b1;
            we_n_d = 1'b1;
            if (cyc.req) begin
               addr_d = cyc.addr;
               ce_n_d = 1'b0;
               if (cyc.wr) begin
                  dq_d = cyc.wdata;
                  dq_oe_d = 1'b1;
                  we_n_d = 1'b0; // RQ2
                  st_d = C_WR_LOW;
               end else begin
                  dq_oe_d = 1'b0;
                  oe_n_d = 1'b0;
                  st_d = C_RD_ACC;
               end
            end
         end
         C_WR_LOW: begin
            if (cnt_q == WP_LAST) begin
               we_n_d = 1'b1;
               ce_n_d = 1'b1;
               cnt_d = '0;
               st_d = C_WR_HIGH;
            end
         end
         C_WR_HIGH: begin
            if (cnt_q == WPH_LAST) begin
               dq_oe_d = 1'b0;
               done_d = 1'b1;
               st_d = C_IDLE;
            end
         end
         C_RD_ACC: begin
            if (cnt_q == RD_LAST) begin
               rdata_d = dq_s_q;
               ce_n_d = 1'b1;
               oe_n_d = 1'b1;
               cnt_d = '0;
               st_d = C_RD_REC;
            end
         end
         C_RD_REC: begin
            // high time between reads doubles as float time before driving
            if (cnt_q == REC_LAST) begin
               done_d = 1'b1;
               st_d = C_IDLE;
            end
         end
         default: st_d = C_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= C_IDLE;
         cnt_q <= '0;
         ce_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         dq_oe_q <= 1'b0;
         addr_q <= '0;
         dq_q <= '0;
         rdata_q <= '0;
         done_q <= 1'b0;
         dq_m_q <= '0;
         dq_s_q <= '0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         ce_n_q <= ce_n_d;
         oe_n_q <= oe_n_d;
         we_n_q <= we_n_d;
         dq_oe_q <= dq_oe_d;
         addr_q <= addr_d;
         dq_q <= dq_d;
         rdata_q <= rdata_d;
         done_q <= done_d;
         dq_m_q <= dq_i;
         dq_s_q <= dq_m_q;
      end
   end

   assign ce_n_o = ce_n_q;
   assign oe_n_o = oe_n_q;
   assign we_n_o = we_n_q;
   assign addr_o = addr_q;
   assign dq_o = dq_q;
   assign dq_oe_o = dq_oe_q;
   assign cyc.done = done_q;
   assign cyc.rdata = rdata_q;

endmodule : pin_cycle_engine

// file: dv/host_properties.sv
// assertion checker on the pins and user port of the eeprom host
`timescale 1ns/1ns
module host_props
   import eeprom_host_pkg::*;
(
   // clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // user port
   input wire logic cmd_ready_o,
   input wire op_e cmd_op_i,
   input wire logic busy_o,
   input wire logic rd_valid_o,
   input wire logic timeout_o,
   // pins
   input wire logic ce_n_o,
   input wire logic oe_n_o,
   input wire logic we_n_o,
   input wire logic [ADDR_W-1:0] addr_o,
   input wire logic [DATA_W-1:0] dq_o,
   input wire logic dq_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_we_with_ce: assert property (!we_n_o |-> !ce_n_o)
      else $error("write strobe without chip select");
   a_oe_in_write: assert property (!we_n_o |-> oe_n_o && dq_oe_o)
      else $error("output enable low in a write");
   a_no_contention: assert property (!oe_n_o |-> !dq_oe_o && we_n_o)
      else $error("host drives data in a read");
   a_page_hold: assert property (!we_n_o && $past(!we_n_o)
      |-> $stable(addr_o) && $stable(dq_o))
      else $error("address or data moved under strobe");
   a_we_width: assert property ($fell(we_n_o) |=> (!we_n_o) [*8])
      else $error("write strobe too short");
   a_strobe_end: assert property ($rose(we_n_o) |-> $rose(ce_n_o))
      else $error("chip select held past strobe");
   a_idle_pins: assert property (!busy_o |-> ce_n_o && we_n_o && !dq_oe_o)
      else $error("pins active while idle");
   a_busy_refuse: assert property (busy_o && cmd_ready_o |-> cmd_op_i == OP_WRITE)
      else $error("command taken while busy");
   a_rd_pulse: assert property (rd_valid_o |-> !busy_o ##1 !rd_valid_o)
      else $error("read answer not a single pulse");
   a_timeout_pulse: assert property (timeout_o |=> !timeout_o)
      else $error("timeout not a single pulse");
   c_read: cover property (rd_valid_o);
   c_timeout: cover property (timeout_o);
   c_page_take: cover property (busy_o && cmd_ready_o);
   c_done: cover property ($fell(busy_o));
endmodule : host_props

bind eeprom_page_host host_props i_props (.clk_i(clk_i), .rstn_i(rstn_i),
   .cmd_ready_o(cmd_ready_o), .cmd_op_i(cmd_op_i), .busy_o(busy_o), .rd_valid_o(rd_valid_o),
   .timeout_o(timeout_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o),
   .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o));

// file: dv/eeprom_device_model.sv
// behavioural model of the paged parallel eeprom seen at its pins
`timescale 1ns/1ns
module eeprom_device_model #(
   parameter int WIN_CYC = 40,
   parameter int PROG_CYC = 60
) (
   // clock
   input wire logic clk_i,
   // pins from the host
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [16:0] addr_i,
   input wire logic [7:0] dq_i,
   // holds the program cycle open while high
   input wire logic stuck_i,
   // answer on the data pins
   output logic [7:0] dq_o,
   output logic drv_o
);
   logic [7:0] mem [0:131071];
   logic [7:0] pd [$];
   logic [16:0] pa [$];
   logic [16:0] wa = 17'h00000;
   logic [7:0] lastw = 8'h00;
   logic act_q = 1'b0;
   logic oe_q = 1'b1;
   logic tog = 1'b0;
   logic locked = 1'b0;
   logic lock_nx = 1'b0;
   logic act;
   int idle = 0;
   int prog = 0;
   initial for (int i = 0; i < 131072; i++) mem[i] = i[7:0] ^ 8'h5a;
   assign act = !ce_n_i && !we_n_i && oe_n_i;
   assign drv_o = !ce_n_i && !oe_n_i && we_n_i;
   assign dq_o = (prog > 0) ? {~lastw[7], tog, lastw[5:0]} : mem[addr_i];
   task automatic commit();
      bit on;
      bit off;
      on = 1'b1;
      off = 1'b1;
      for (int k = 0; k < 3; k++) begin
         if (k < pa.size()) begin
            on &= (pa[k][14:0] == 15'(k + 1)) && (pd[k] == 8'(k + 1));
            off &= (pa[k][14:0] == 15'(k + 1)) && (pd[k] == 8'(k + 4));
         end else begin
            on = 1'b0;
            off = 1'b0;
         end
      end
      lock_nx <= on ? 1'b1 : (off ? 1'b0 : locked);
      for (int k = (on || off) ? 3 : 0; k < pa.size(); k++)
         if (on || off || !locked) mem[pa[k]] <= pd[k];
      pa.delete();
      pd.delete();
      prog <= PROG_CYC;
   endtask : commit
   always @(posedge clk_i) begin
      act_q <= act;
      oe_q <= oe_n_i;
      if (act && !act_q) wa <= addr_i;
      if (!oe_q && oe_n_i && prog > 0) tog <= ~tog;
      if (prog > 0) begin
         if (!stuck_i) prog <= prog - 1;
         if (prog == 1 && !stuck_i) locked <= lock_nx;
      end else if (act_q && !act) begin
         pa.push_back(wa);
         pd.push_back(dq_i);
         lastw <= dq_i;
         idle <= 0;
      end else if (pa.size() > 0) begin
         idle <= idle + 1;
         // a read also ends the load
         if (idle >= WIN_CYC || drv_o) commit();
      end
   end
endmodule : eeprom_device_model

// file: dv/tb_top.sv
// self-checking bench for the paged eeprom host controller
`timescale 1ns/1ns
module tb_top;
   import eeprom_host_pkg::*;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   op_e cmd_op_i = OP_READ;
   logic [ADDR_W-1:0] cmd_addr_i = 17'h00000;
   logic [DATA_W-1:0] cmd_data_i = 8'h00;
   logic wr_locked_i = 1'b0;
   logic stuck = 1'b0;
   logic cmd_ready_o, rd_valid_o, busy_o, timeout_o, ce_n_o, oe_n_o, we_n_o, dq_oe_o, m_drv;
   logic [ADDR_W-1:0] addr_o;
   logic [DATA_W-1:0] rd_data_o, dq_o, m_dq, bus;
   logic [DATA_W-1:0] bus_last = 8'h00;
   int miscompares = 0;
   int compares = 0;
   int cyc = 0;
   initial forever #5 clk_i = ~clk_i;
   // a released bus shows a changing pattern
   assign bus = dq_oe_o ? dq_o : (m_drv ? m_dq : ~bus_last);
   always @(posedge clk_i) bus_last <= bus;
   eeprom_page_host #(.LOAD_IDLE_CYC(20), .POLL_LIMIT_CYC(200)) i_dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
      .cmd_op_i(cmd_op_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
      .wr_locked_i(wr_locked_i), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o),
      .busy_o(busy_o), .timeout_o(timeout_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
      .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o), .dq_i(bus));
   eeprom_device_model i_model (.clk_i(clk_i), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
      .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(bus), .stuck_i(stuck), .dq_o(m_dq),
      .drv_o(m_drv));
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic cmd(input op_e op, input logic [16:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cmd_valid_i <= 1'b1;
      cmd_op_i <= op;
      cmd_addr_i <= a;
      cmd_data_i <= d;
      do @(negedge clk_i); while (cmd_ready_o !== 1'b1);
      @(posedge clk_i);
      cmd_valid_i <= 1'b0;
   endtask : cmd
   task automatic wait_idle();
      repeat (3) @(negedge clk_i);
      while (busy_o !== 1'b0) @(negedge clk_i);
   endtask : wait_idle
   task automatic rd(input logic [16:0] a, input logic [7:0] exp);
      cmd(OP_READ, a, 8'h00);
      do @(negedge clk_i); while (rd_valid_o !== 1'b1);
      check(rd_data_o, exp);
   endtask : rd
   task automatic t_read();
      check({4'h0, ce_n_o, oe_n_o, we_n_o, dq_oe_o}, 8'h0e);
      rd(17'h00123, 8'h23 ^ 8'h5a);
      rd(17'h1ff80, 8'h80 ^ 8'h5a);
      $display("test read done");
   endtask : t_read
   task automatic t_page();
      for (int i = 0; i < PAGE_BYTES; i++)
         cmd(OP_WRITE, 17'h00180 + 17'(i), 8'(i) ^ 8'ha5);
      // the read closes the open page first
      rd(17'h00180, 8'ha5);
      rd(17'h001ff, 8'h7f ^ 8'ha5);
      rd(17'h00200, 8'h00 ^ 8'h5a);
      $display("test page done");
   endtask : t_page
   task automatic t_lock();
      cmd(OP_LOCK_ON, 17'h00201, 8'h00);
      wait_idle();
      cmd(OP_WRITE, 17'h00200, 8'h11);
      rd(17'h00200, 8'h5a);
      @(posedge clk_i);
      wr_locked_i <= 1'b1;
      cmd(OP_WRITE, 17'h00201, 8'h22);
      rd(17'h00201, 8'h22);
      @(posedge clk_i);
      wr_locked_i <= 1'b0;
      cmd(OP_LOCK_OFF, 17'h00201, 8'h00);
      wait_idle();
      cmd(OP_WRITE, 17'h00202, 8'h33);
      rd(17'h00202, 8'h33);
      $display("test lock done");
   endtask : t_lock
   task automatic t_timeout();
      logic seen;
      seen = 1'b0;
      @(posedge clk_i);
      stuck <= 1'b1;
      cmd(OP_WRITE, 17'h00300, 8'h44);
      do begin
         @(negedge clk_i);
         seen |= (timeout_o === 1'b1);
      end while (busy_o !== 1'b0);
      check({7'h00, seen}, 8'h01);
      @(posedge clk_i);
      stuck <= 1'b0;
      // the model needs its program period to finish
      repeat (70) @(posedge clk_i);
      rd(17'h00300, 8'h44);
      $display("test timeout done");
   endtask : t_timeout
   initial begin
      repeat (6) @(posedge clk_i);
      rstn_i <= 1'b1;
      t_read();
      t_page();
      t_lock();
      t_timeout();
      print_verdict();
   end
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         miscompares++;
         print_verdict();
      end
   end
endmodule : tb_top
